/* rtl/shared_ram_arb_pkg.sv */
// Package: offsets, status layout, timing constants and carriers for the shared RAM arbiter
package shared_ram_arb_pkg;

  // Host I/O offsets relative to the module base address
  localparam logic [4:0] OFS_POINTER   = 5'h00;
  localparam logic [4:0] OFS_WORD      = 5'h01;
  localparam logic [4:0] OFS_WORD_INC  = 5'h02;
  localparam logic [4:0] OFS_BYTE      = 5'h03;
  localparam logic [4:0] OFS_BYTE_INC  = 5'h04;
  localparam logic [4:0] OFS_TIMEOUT   = 5'h08;
  localparam logic [4:0] OFS_CONFIG    = 5'h0C;
  localparam logic [4:0] OFS_LOCK      = 5'h18;
  localparam logic [4:0] OFS_STATUS    = 5'h19;

  // Lock request codes written at the lock offset
  localparam logic [7:0] LOCK_NONE     = 8'h00;
  localparam logic [7:0] LOCK_READ     = 8'h01;
  localparam logic [7:0] LOCK_WRITE    = 8'h02;

  // Field positions
  localparam int CFG_MODE_BIT          = 5;
  localparam int ST_TIMEOUT            = 0;
  localparam int ST_READ_LOCK          = 1;
  localparam int ST_WRITE_LOCK         = 2;
  localparam int ST_CTRL_REQ           = 3;
  localparam int ST_CTRL_SEL_N         = 4;
  localparam int ST_GRANT_N            = 5;
  localparam int ST_CONFLICT           = 6;

  // Reset values
  localparam logic [13:0] POINTER_RST  = 14'h0000;
  localparam logic [15:0] RELOAD_RST   = 16'h0000;
  localparam logic [15:0] COUNTER_RST  = 16'hFFFF;
  localparam logic [7:0]  CONFIG_RST   = 8'h00;

  // Pointer steps after auto-increment
  localparam logic [13:0] STEP_WORD    = 14'h0002;
  localparam logic [13:0] STEP_BYTE    = 14'h0001;

  // Timeout tick: 16-bit count spans about 0.65 s
  localparam int CLK_PERIOD_NS         = 100;
  localparam int TICK_NS               = 10000;
  localparam int TICK_CYCLES           = TICK_NS / CLK_PERIOD_NS;
  localparam logic [7:0] TICK_LAST     = 8'(TICK_CYCLES - 1);

  // Host access sequencer, one-hot
  typedef enum logic [3:0] {
    ACC_IDLE  = 4'b0001,
    ACC_STALL = 4'b0010,
    ACC_RAM   = 4'b0100,
    ACC_DATA  = 4'b1000
  } acc_state_type;

  // Shared RAM port toward the memory
  typedef struct packed {
    logic        en;
    logic        we;
    logic [1:0]  be;
    logic [12:0] addr;
    logic [15:0] wdata;
  } ram_port_type;

  // Latched host request
  typedef struct packed {
    logic        is_write;
    logic        is_byte;
    logic        inc;
    logic [15:0] wdata;
  } host_req_type;

endpackage

/* rtl/shared_ram_consistency_arbiter.sv */
// Shared RAM access and lock arbitration between the host board and the protocol controller
`timescale 1ns/10ps

// Summary of operation
// R1: 14-bit pointer addresses shared RAM
// R2: pointer bit 0 picks low/high byte
// R3: word access ignores pointer bit 0
// R4: I/O offset selects byte or word width
// R5: offset selects auto-increment, 2 or 1
// R6: pointer range 0000h to 3FFFh
// R7: pointer loaded at offset 00h first
// R8: host lock request precedes RAM access
// R9: status read at lock offset ends lock
// R10: controller wins when both request
// R11: host stalled while controller holds lock
// R12: controller request and grant readable
// R13: grant held during valid host lock
// R14: controller stalled while host lock active
// R15: host ends lock within 80 us
// R16: timeout mode timer aborts host lock
// R17: status returns seven lock state flags
// R18: timeout sets expired flag, data invalid
// R19: 16-bit reload written at offset 08h
// R20: host picks timeout from FIFO size
// R21: interrupt mode sets conflict flag only
// R22: config bit 5 selects conflict mode
// R23: reset clears registers, counter all ones
// R24: write 01h/02h requests read/write lock
// R25: write 00h clears error, unblocks RAM
// R26: auto-increment wraps within 14 bits
module shared_ram_consistency_arbiter
  import shared_ram_arb_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic [4:0]  io_addr,
  input  wire logic [15:0] io_wdata,
  input  wire logic        io_rd,
  input  wire logic        io_wr,
  output logic [15:0]      io_rdata,
  output logic             io_rdata_valid,
  output logic             host_side_ready,
  output logic             host_select_n,
  input  wire logic        controller_lock_request,
  output logic             controller_side_ready,
  output logic             controller_ram_select_n,
  output logic             lock_grant_n,
  output ram_port_type     ram,
  input  wire logic [15:0] ram_rdata
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    acc_state_type acc;
    host_req_type  req;
    ram_port_type  ram;
    logic [13:0]   pointer;
    logic [15:0]   reload;
    logic [15:0]   counter;
    logic [7:0]    tick;
    logic [7:0]    config_reg;
    logic          read_lock;
    logic          write_lock;
    logic          granted;
    logic          ctrl_owns;
    logic          ctrl_req_d;
    logic          timer_run;
    logic          timed_out;
    logic          conflict;
    logic          blocked;
    logic [15:0]   rdata;
    logic          rvalid;
    logic          ready;
    logic          select_n;
    logic          ctrl_ready;
    logic          ctrl_sel_n;
  } state_type;

  state_type cur;
  state_type next_cur;

  logic        host_lock;
  logic        ram_offset;
  logic        ram_free;
  logic [7:0]  status_byte;
  logic [13:0] step;
  logic        ctrl_rise;
  logic        expire;

  ////////////////////////////////////////////////////////////////////////////
  // Helper terms

  // Host lock is any of the two lock kinds
  assign host_lock  = cur.read_lock | cur.write_lock;
  // Width and increment come from the offset alone, never the pointer
  assign ram_offset = (io_addr == OFS_WORD) || (io_addr == OFS_WORD_INC) ||
                      (io_addr == OFS_BYTE) || (io_addr == OFS_BYTE_INC);     // see R4
  // Host may touch the RAM only when the controller neither owns it nor takes it this cycle
  assign ram_free   = !cur.ctrl_owns && !(controller_lock_request && !cur.granted); // see R11
  // Controller request edge seen while the host holds the grant
  assign ctrl_rise  = controller_lock_request && !cur.ctrl_req_d && cur.granted;
  // Last tick of the last count: the host lock is aborted
  assign expire     = cur.timer_run && host_lock && (cur.tick == TICK_LAST) && (cur.counter == 16'h0000);
  assign step       = cur.req.is_byte ? STEP_BYTE : STEP_WORD;                // see R5

  // Status layout shared by both status offsets
  always_comb begin
    status_byte                = 8'h00;
    status_byte[ST_TIMEOUT]    = cur.timed_out;                               // see R17
    status_byte[ST_READ_LOCK]  = cur.read_lock;
    status_byte[ST_WRITE_LOCK] = cur.write_lock;
    status_byte[ST_CTRL_REQ]   = controller_lock_request;                     // see R12
    status_byte[ST_CTRL_SEL_N] = cur.ctrl_sel_n;
    status_byte[ST_GRANT_N]    = !cur.granted;
    status_byte[ST_CONFLICT]   = cur.conflict;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_cur            = cur;
    next_cur.rvalid     = 1'b0;
    next_cur.ram.en     = 1'b0;
    next_cur.ram.we     = 1'b0;
    next_cur.ctrl_req_d = controller_lock_request;

    // Controller ownership: it takes the RAM whenever the host is not granted
    if (!controller_lock_request) begin
      next_cur.ctrl_owns = 1'b0;
    end else if (!cur.granted) begin
      next_cur.ctrl_owns = 1'b1;                                              // see R10
    end

    // Grant: only when no controller request is pending, held until lock ends
    if (!host_lock) begin
      next_cur.granted = 1'b0;
    end else if (!cur.ctrl_owns && !controller_lock_request) begin
      next_cur.granted = 1'b1;                                                // see R13
    end

    // Controller event while host holds the grant
    if (controller_lock_request && !cur.ctrl_req_d && cur.granted) begin
      if (cur.config_reg[CFG_MODE_BIT]) begin
        next_cur.conflict = 1'b1;                                             // see R21 see R22
      end else begin
        next_cur.timer_run = 1'b1;                                            // see R16 see R22
        next_cur.counter   = cur.reload;
        next_cur.tick      = 8'h00;
      end
    end

    // Timeout countdown in ticks of ten microseconds
    if (cur.timer_run) begin
      if (!host_lock) begin
        next_cur.timer_run = 1'b0;
      end else if (cur.tick == TICK_LAST) begin
        next_cur.tick = 8'h00;
        if (cur.counter == 16'h0000) begin
          // Abort: deselect host, drop lock, block RAM until error cleared
          next_cur.timer_run  = 1'b0;
          next_cur.timed_out  = 1'b1;                                         // see R18
          next_cur.read_lock  = 1'b0;                                         // see R16
          next_cur.write_lock = 1'b0;
          next_cur.granted    = 1'b0;
          next_cur.blocked    = 1'b1;                                         // see R25
        end else begin
          next_cur.counter = cur.counter - 16'h0001;
        end
      end else begin
        next_cur.tick = cur.tick + 8'h01;
      end
    end

    // Register side of the host bus
    case (cur.acc)
      ACC_IDLE: begin
        if (io_wr && !ram_offset) begin
          next_cur.rvalid = 1'b1;
          case (io_addr)
            OFS_POINTER: next_cur.pointer = io_wdata[13:0];                   // see R1 see R7
            OFS_TIMEOUT: next_cur.reload  = io_wdata;                         // see R19
            OFS_CONFIG:  next_cur.config_reg = io_wdata[7:0];
            OFS_LOCK: begin
              // Any lock write clears the conflict flag; code 00h clears the error
              next_cur.conflict = 1'b0;
              if (io_wdata[7:0] == LOCK_READ) begin
                next_cur.read_lock  = !cur.blocked;                           // see R24 see R8
                next_cur.write_lock = 1'b0;
              end else if (io_wdata[7:0] == LOCK_WRITE) begin
                next_cur.write_lock = !cur.blocked;                           // see R24
                next_cur.read_lock  = 1'b0;
              end else if (io_wdata[7:0] == LOCK_NONE) begin
                next_cur.read_lock  = 1'b0;
                next_cur.write_lock = 1'b0;
                next_cur.timed_out  = 1'b0;                                   // see R25
                next_cur.blocked    = 1'b0;
              end
            end
            default: ;
          endcase
        end else if (io_rd && !ram_offset) begin
          next_cur.rvalid = 1'b1;
          next_cur.rdata  = 16'h0000;
          case (io_addr)
            OFS_STATUS: next_cur.rdata = {8'h00, status_byte};
            OFS_CONFIG: next_cur.rdata = {8'h00, cur.config_reg};
            OFS_LOCK: begin
              // Ending read: status shows the state before the lock drops
              next_cur.rdata      = {8'h00, status_byte};                     // see R9 see R17
              next_cur.read_lock  = 1'b0;
              next_cur.write_lock = 1'b0;
            end
            default: ;
          endcase
        end else if ((io_rd || io_wr) && ram_offset) begin
          next_cur.req.is_write = io_wr;
          next_cur.req.is_byte  = (io_addr == OFS_BYTE) || (io_addr == OFS_BYTE_INC);
          next_cur.req.inc      = (io_addr == OFS_WORD_INC) || (io_addr == OFS_BYTE_INC); // see R5
          next_cur.req.wdata    = io_wdata;
          next_cur.ready        = 1'b0;
          next_cur.acc          = ACC_STALL;
        end
      end
      ACC_STALL: begin
        if (cur.blocked) begin
          // Refused after timeout: no RAM cycle, reads return zero
          next_cur.rdata  = 16'h0000;
          next_cur.rvalid = 1'b1;
          next_cur.ready  = 1'b1;
          next_cur.acc    = ACC_IDLE;
        end else if (ram_free) begin
          next_cur.ram.en    = 1'b1;
          next_cur.ram.we    = cur.req.is_write;
          next_cur.ram.addr  = cur.pointer[13:1];                             // see R6
          next_cur.ram.wdata = cur.req.wdata;
          // Word access ignores bit 0; byte access uses it as lane select
          if (cur.req.is_byte) begin
            next_cur.ram.be = cur.pointer[0] ? 2'b10 : 2'b01;                 // see R2
          end else begin
            next_cur.ram.be = 2'b11;                                          // see R3
          end
          next_cur.acc = ACC_RAM;
        end
      end
      ACC_RAM: begin
        next_cur.acc = ACC_DATA;
      end
      ACC_DATA: begin
        if (!cur.req.is_write) begin
          next_cur.rdata = ram_rdata & {{8{cur.ram.be[1]}}, {8{cur.ram.be[0]}}};
        end
        if (cur.req.inc) begin
          next_cur.pointer = cur.pointer + step;                              // see R26
        end
        next_cur.rvalid = 1'b1;
        next_cur.ready  = 1'b1;
        next_cur.acc    = ACC_IDLE;
      end
      default: begin
        next_cur.acc   = ACC_IDLE;
        next_cur.ready = 1'b1;
      end
    endcase

    // Set and clear in one cycle: the set wins, and an abort beats a lock write
    if (ctrl_rise && cur.config_reg[CFG_MODE_BIT]) begin
      next_cur.conflict = 1'b1;                                               // see R21
    end
    if (expire) begin
      next_cur.read_lock  = 1'b0;                                             // see R16
      next_cur.write_lock = 1'b0;
      next_cur.granted    = 1'b0;
      next_cur.timed_out  = 1'b1;                                             // see R18
      next_cur.blocked    = 1'b1;                                             // see R25
    end

    // Pin-side views, registered
    next_cur.select_n   = next_cur.blocked;                                   // see R16
    next_cur.ctrl_ready = !(next_cur.granted && controller_lock_request);     // see R14
    next_cur.ctrl_sel_n = !next_cur.ctrl_owns;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  // Synchronous reset; clock enable freezes everything
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cur            <= '0;
      cur.acc        <= ACC_IDLE;
      cur.pointer    <= POINTER_RST;                                          // see R23
      cur.reload     <= RELOAD_RST;
      cur.counter    <= COUNTER_RST;
      cur.config_reg <= CONFIG_RST;
      cur.ready      <= 1'b1;
      cur.select_n   <= 1'b0;
      cur.ctrl_ready <= 1'b1;
      cur.ctrl_sel_n <= 1'b1;
    end else if (ce) begin
      cur <= next_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, straight from the state register

  assign io_rdata                = cur.rdata;
  assign io_rdata_valid          = cur.rvalid;
  assign host_side_ready         = cur.ready;
  assign host_select_n           = cur.select_n;
  assign controller_side_ready   = cur.ctrl_ready;
  assign controller_ram_select_n = cur.ctrl_sel_n;
  assign lock_grant_n            = !cur.granted;                              // see R12
  assign ram                     = cur.ram;

endmodule

/* test/shared_ram_arb_props.sv */
// Port-level checks for the shared RAM arbiter
`timescale 1ns/10ps
module shared_ram_arb_props
  import shared_ram_arb_pkg::*;
(
  input wire logic         clk,
  input wire logic         rst_n,
  input wire logic         ce,
  input wire logic [4:0]   io_addr,
  input wire logic [15:0]  io_wdata,
  input wire logic         io_rd,
  input wire logic         io_wr,
  input wire logic         io_rdata_valid,
  input wire logic         host_side_ready,
  input wire logic         host_select_n,
  input wire logic         controller_lock_request,
  input wire logic         controller_side_ready,
  input wire logic         controller_ram_select_n,
  input wire logic         lock_grant_n,
  input wire ram_port_type ram
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  // Lock offset touched; such accesses may legally end or clear a lock
  wire lock_touch = ce && (io_rd || io_wr) && io_addr == OFS_LOCK;
  wire clr_err    = ce && io_wr && io_addr == OFS_LOCK && io_wdata[7:0] == LOCK_NONE;
  // Uncontended word read and its four-cycle walk
  sequence free_word_rd;
    (ce && host_side_ready && io_rd && io_addr == OFS_WORD && !host_select_n
      && controller_ram_select_n && !controller_lock_request) ##1 (ce && !controller_lock_request);
  endsequence
  sequence word_walk;
    !host_side_ready ##1 (ram.en && !ram.we && ram.be == 2'b11) ##2 (io_rdata_valid && host_side_ready);
  endsequence
  ////////////////////////////////////////////////////////////////////////
  AST_WORD_WALK: assert property (free_word_rd |-> word_walk)
    else $error("word read walk broken");
  AST_CTRL_OWNS: assert property (!controller_ram_select_n |-> !ram.en)
    else $error("host RAM cycle while controller owns RAM");
  AST_ONE_OWNER: assert property (!lock_grant_n |-> controller_ram_select_n)
    else $error("grant and controller ownership together");
  AST_CTRL_STALL: assert property (ce && !lock_grant_n && controller_lock_request |=> !controller_side_ready || lock_grant_n)
    else $error("controller not stalled under host lock");
  AST_GRANT_HOLD: assert property (!lock_grant_n && !lock_touch && !$past(lock_touch) |=>
    !lock_grant_n || host_select_n)
    else $error("grant dropped without release or abort");
  AST_ABORT: assert property ($rose(host_select_n) && controller_lock_request |-> lock_grant_n ##[1:3] !controller_ram_select_n)
    else $error("abort did not hand RAM to controller");
  AST_BLOCK_HOLD: assert property (host_select_n && !clr_err |=> host_select_n)
    else $error("host deselect left without clear");
  AST_STATUS_ANS: assert property (ce && host_side_ready && io_rd && io_addr == OFS_STATUS |=> io_rdata_valid)
    else $error("status read not answered");
endmodule

bind shared_ram_consistency_arbiter shared_ram_arb_props u_props (.clk(clk), .rst_n(rst_n), .ce(ce), .io_addr(io_addr),
  .io_wdata(io_wdata), .io_rd(io_rd), .io_wr(io_wr), .io_rdata_valid(io_rdata_valid), .ram(ram),
  .host_side_ready(host_side_ready), .host_select_n(host_select_n), .lock_grant_n(lock_grant_n),
  .controller_lock_request(controller_lock_request), .controller_side_ready(controller_side_ready),
  .controller_ram_select_n(controller_ram_select_n));

/* test/shared_ram_model.sv */
// Behavioural shared RAM behind the arbiter's memory port
`timescale 1ns/10ps
module shared_ram_model
  import shared_ram_arb_pkg::*;
(
  input  wire logic         clk,
  input  wire ram_port_type ram,
  output logic [15:0]       ram_rdata
);
  logic [15:0] mem [0:8191];
  initial begin
    foreach (mem[j]) mem[j] = 16'h0000;
    ram_rdata = 16'h0000;
  end
  // Lanes written by byte enable; read data stands one cycle, then flips so a late sample is caught
  always @(posedge clk) begin
    if (ram.en && ram.we && ram.be[0]) mem[ram.addr][7:0] <= ram.wdata[7:0];
    if (ram.en && ram.we && ram.be[1]) mem[ram.addr][15:8] <= ram.wdata[15:8];
    if (ram.en && !ram.we) ram_rdata <= mem[ram.addr];
    else ram_rdata <= ~ram_rdata;
  end
endmodule

/* test/test_shared_ram_consistency_arbiter.sv */
// Self-checking bench for the shared RAM arbiter
`timescale 1ns/10ps
module test_shared_ram_consistency_arbiter;
  import shared_ram_arb_pkg::*;
  logic         clk, rst_n, ce, io_rd, io_wr, clr, io_rdata_valid, host_side_ready, host_select_n;
  logic         controller_side_ready, controller_ram_select_n, lock_grant_n;
  logic [4:0]   io_addr;
  logic [13:0]  ptr, p;
  logic [15:0]  io_wdata, io_rdata, ram_rdata, q;
  logic [15:0]  mem [0:8191];
  ram_port_type ram;
  int           n_errors, comparisons, seed, i;
  shared_ram_consistency_arbiter uut (.clk(clk), .rst_n(rst_n), .ce(ce), .io_addr(io_addr), .io_wdata(io_wdata),
    .io_rd(io_rd), .io_wr(io_wr), .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid), .ram(ram),
    .host_side_ready(host_side_ready), .host_select_n(host_select_n), .controller_lock_request(clr),
    .controller_side_ready(controller_side_ready), .controller_ram_select_n(controller_ram_select_n),
    .lock_grant_n(lock_grant_n), .ram_rdata(ram_rdata));
  shared_ram_model u_ram (.clk(clk), .ram(ram), .ram_rdata(ram_rdata));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One host I/O cycle; strobe is a single pulse, answer waited for under a bound
  task automatic io(input logic wr, input logic [4:0] a, input logic [15:0] d);
    int k;
    @(negedge clk);
    io_addr = a;
    io_wdata = d;
    io_wr = wr;
    io_rd = !wr;
    @(negedge clk);
    io_wr = 1'b0;
    io_rd = 1'b0;
    for (k = 0; k < 500 && io_rdata_valid !== 1'b1; k++) @(negedge clk);
    if (k == 500) chk("answer", 16'h0001, 16'h0000);
    q = io_rdata;
  endtask
  task automatic setp(input logic [13:0] v);
    ptr = v;
    io(1'b1, OFS_POINTER, {2'b00, v});
  endtask
  // Mode: bit 1 byte, bit 0 auto-increment; the bench mirror tracks RAM and pointer
  task automatic acc(input logic wr, input logic [1:0] m, input logic [15:0] d);
    logic [15:0] mask;
    mask = !m[1] ? 16'hFFFF : ptr[0] ? 16'hFF00 : 16'h00FF;
    if (wr) mem[ptr[13:1]] = (mem[ptr[13:1]] & ~mask) | (d & mask);
    io(wr, OFS_WORD + 5'(m), d);
    if (!wr) chk("ram data", mem[ptr[13:1]] & mask, q & mask);
    if (m[0]) ptr = ptr + (m[1] ? 14'h0001 : 14'h0002);
  endtask
  task automatic st(input logic [4:0] a, input logic [6:0] e, input string w);
    io(1'b0, a, 16'h0000);
    chk(w, {9'h000, e}, {9'h000, q[6:0]});
  endtask
  task automatic lock(input logic [7:0] code);
    int k;
    io(1'b1, OFS_LOCK, {8'h00, code});
    io(1'b0, OFS_STATUS, 16'h0000);
    for (k = 0; k < 20 && q[ST_GRANT_N] !== 1'b0; k++) io(1'b0, OFS_STATUS, 16'h0000);
    chk("grant", 16'h0000, {15'h0000, q[ST_GRANT_N]});
  endtask
  task automatic conclude;
    $display("Counts: %0d comparisons, %0d errors", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Watchdog well beyond the fewer than a thousand cycles the run needs
  initial begin
    #(20000 * 100);
    n_errors++;
    conclude();
  end
  initial begin
    {rst_n, io_rd, io_wr, clr, io_addr, io_wdata, ptr} = '0;
    ce = 1'b1;
    seed = 32'h6676;
    foreach (mem[j]) mem[j] = 16'h0000;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    chk("reset pins", 16'h002E, {10'h000, lock_grant_n, host_select_n, host_side_ready, controller_side_ready,
      controller_ram_select_n, ram.en});
    st(OFS_STATUS, 7'h30, "reset status");
    io(1'b0, OFS_CONFIG, 16'h0000);
    chk("config reset", 16'h0000, q);
    io(1'b0, 5'h1F, 16'h0000);
    chk("unmapped read", 16'h0000, q);
    // Clock enable low: a held strobe is not taken and nothing answers
    @(negedge clk);
    ce = 1'b0;
    io_addr = OFS_STATUS;
    io_rd = 1'b1;
    repeat (3) @(negedge clk);
    chk("frozen answer", 16'h0000, {15'h0000, io_rdata_valid});
    io_rd = 1'b0;
    ce = 1'b1;
    $display("test reset done");
    // Random mixed-width traffic, writes then reads from the same start; second group wraps the top
    for (i = 0; i < 48; i++) begin
      if (i % 8 == 0) p = (i == 8) ? 14'h3FFD : 14'($random(seed));
      if (i % 4 == 0) setp(p);
      acc(i % 8 < 4, 2'($random(seed)), 16'($random(seed)));
    end
    $display("test random access done");
    // Read and write lock codes; the status read at the lock offset ends each lock
    for (i = 1; i <= 2; i++) begin
      lock(8'(i));
      acc(1'b1, 2'b01, 16'h5AA5);
      st(OFS_LOCK, 7'h10 | 7'(i << 1), "lock status");
      repeat (2) @(negedge clk);
      chk("grant released", 16'h0001, {15'h0000, lock_grant_n});
    end
    $display("test lock codes done");
    // Controller holds RAM first: host lock waits, host RAM access stalls
    clr = 1'b1;
    io(1'b1, OFS_LOCK, {8'h00, LOCK_READ});
    st(OFS_STATUS, 7'h2A, "controller first");
    fork
      acc(1'b0, 2'b00, 16'h0000);
      begin
        repeat (20) @(negedge clk);
        chk("host stalled", 16'h0000, {15'h0000, host_side_ready});
        clr = 1'b0;
      end
    join
    lock(LOCK_READ);
    st(OFS_LOCK, 7'h12, "late grant");
    $display("test priority done");
    // Timeout mode: reload 1 gives 200 cycles before the host lock is aborted
    io(1'b1, OFS_TIMEOUT, 16'h0001);
    lock(LOCK_WRITE);
    clr = 1'b1;
    repeat (3) @(negedge clk);
    chk("controller stalled", 16'h0000, {15'h0000, controller_side_ready});
    repeat (175) @(negedge clk);
    chk("grant before expiry", 16'h0000, {15'h0000, lock_grant_n});
    repeat (40) @(negedge clk);
    chk("abort pins", 16'h0006, {13'h0000, lock_grant_n, host_select_n, controller_ram_select_n});
    clr = 1'b0;
    st(OFS_LOCK, 7'h31, "timed out");
    io(1'b0, OFS_WORD, 16'h0000);
    chk("blocked read", 16'h0000, q);
    io(1'b1, OFS_LOCK, {8'h00, LOCK_NONE});
    st(OFS_STATUS, 7'h30, "error cleared");
    $display("test timeout done");
    // Interrupt mode: conflict flagged, no abort, controller proceeds once host ends
    io(1'b1, OFS_CONFIG, 16'h0020);
    io(1'b0, OFS_CONFIG, 16'h0000);
    chk("config", 16'h0020, {8'h00, q[7:0]});
    lock(LOCK_READ);
    clr = 1'b1;
    repeat (300) @(negedge clk);
    st(OFS_STATUS, 7'h5A, "conflict");
    st(OFS_LOCK, 7'h5A, "end conflict lock");
    repeat (3) @(negedge clk);
    chk("controller owns", 16'h0000, {15'h0000, controller_ram_select_n});
    clr = 1'b0;
    io(1'b1, OFS_LOCK, {8'h00, LOCK_NONE});
    st(OFS_STATUS, 7'h30, "conflict cleared");
    $display("test conflict interrupt done");
    conclude();
  end
endmodule
